// ### rtl/spfs_map.svh
`ifndef SPFS_MAP_SVH
`define SPFS_MAP_SVH
// Register byte offsets on the bus
`define SPFS_OFF_PERIPHERAL_CONFIG_REG 6'h00
`define SPFS_OFF_GPEN 6'h04
`define SPFS_OFF_GPDIR 6'h08
`define SPFS_OFF_GPOUT 6'h0c
`define SPFS_OFF_GPIN 6'h10
`define SPFS_OFF_STATUS 6'h14
// Peripheral config field positions
`define SPFS_CFG_VP1 0
`define SPFS_CFG_AUD0 1
`define SPFS_CFG_BSP1 2
// Peripheral config reset: serial port 1 on, others off
`define SPFS_CFG_RESET 3'h4
// Status field positions
`define SPFS_ST_PCI 0
`define SPFS_ST_ETHER 1
`define SPFS_ST_ETHER_EFF 2
`define SPFS_ST_LATCHED 3
`define SPFS_ST_UP_VIDEO 4
`define SPFS_ST_UP_AUDIO 5
`define SPFS_ST_LOW_BSP 6
// Shared pad positions in the general I/O bank
`define SPFS_GP_DIV4 1
`define SPFS_GP_DIV6 2
`define SPFS_GP_DAC 8
`define SPFS_GP_PCI_LO 9
`define SPFS_GP_PCI_HI 15
// Video port 1 pad ranges
`define SPFS_VP_UP_LO 12
`define SPFS_VP_UP_HI 19
`define SPFS_VP_LOW_LO 2
`define SPFS_VP_LOW_HI 8
// Strap settle cycles after reset release
`define SPFS_STRAP_SETTLE 2'h3
`endif

// ### rtl/spfs_pin_mux.sv
// Notes on behaviour
// - Strap pads latch at reset, one owner
// - Clock pads default divided clocks until enabled
// - GPIO direction: 0 input, 1 driven output
// - DAC default; GPIO 8 needs PCI off
// - GPIO 15:9 need PCI off and enable
// - PCI off holds dedicated PCI pads hi-Z
// - Upper video pads idle after reset
// - Audio enable routes audio data upper pads
// - Video enable gives all pads to video
// - Lower pads default serial port 1
// - PCI and ether straps sampled at reset
// - PCI defaults off; ether ignored under PCI
//
// Local design decisions: the register addresses and the Wishbone interface to the registers.
`include "spfs_map.svh"
module spfs_pin_mux (
  // Clock and reset
  input wire logic clk_i,
  input wire logic reset_i,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [5:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Strap pads
  input wire logic pci_strap_pad_i,
  input wire logic ether_strap_pad_i,
  output logic ether_strap_enable_o,
  // Internal clock and DAC sources
  input wire logic cpu_div4_clock_out_i,
  input wire logic cpu_div6_clock_out_i,
  input wire logic vcxo_dac_out_i,
  // General I/O bank pads
  input wire logic [15:0] general_io_bank_pad_i,
  output logic [15:0] general_io_bank_pad_o,
  output logic [15:0] general_io_bank_pad_oe_o,
  // PCI core side of shared and dedicated pads
  input wire logic [6:0] pci_shared_out_i,
  input wire logic [6:0] pci_shared_oe_i,
  output logic [6:0] pci_shared_in_o,
  input wire logic pci_dedicated_oe_i,
  output logic pci_dedicated_oe_o,
  // Video port 1 data pads
  input wire logic [19:0] video_port1_data_pad_i,
  output logic [19:0] video_port1_data_pad_o,
  output logic [19:0] video_port1_data_pad_oe_o,
  // Video port 1 core
  input wire logic [19:0] video_port1_data_out_i,
  input wire logic [19:0] video_port1_data_oe_i,
  output logic [19:0] video_port1_data_o,
  // Audio port 0 serial data core
  input wire logic [7:0] audio_port0_serial_data_out_i,
  input wire logic [7:0] audio_port0_serial_data_oe_i,
  output logic [7:0] audio_port0_serial_data_o,
  // Serial port 1 core, index 0 on pad 2 up to index 6 on pad 8
  input wire logic [6:0] bsp1_out_i,
  input wire logic [6:0] bsp1_oe_i,
  output logic [6:0] bsp1_in_o
);
  import spfs_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // Helpers

  // Byte-lane merge of a 16-bit register
  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d, input logic [3:0] sel);
    merge16 = old;
    if (sel[0]) begin
      merge16[7:0] = d[7:0];
    end
    if (sel[1]) begin
      merge16[15:8] = d[15:8];
    end
  endfunction : merge16

  // True when GPIO owns a bank pad
  function automatic logic gpio_owns(input int idx, input logic en, input logic pci);
    if (idx >= `SPFS_GP_DAC) begin
      gpio_owns = en & ~pci;
    end else begin
      gpio_owns = en;
    end
  endfunction : gpio_owns

  // Lane of a PCI-shared bank pad
  function automatic logic [2:0] pci_lane(input int idx);
    pci_lane = 3'(idx - `SPFS_GP_PCI_LO);
  endfunction : pci_lane

  ////////////////////////////////////////////////////////////////////////
  // Synchronisers and strap capture

  logic [1:0] strap_sync; // Straps after two flops
  logic [15:0] gp_sync; // Bank pads after two flops
  logic [19:0] vp_sync; // Video pads after two flops
  logic pci_en; // Latched PCI strap
  logic ether_strap_enable; // Latched ether strap
  logic straps_latched; // Capture done

  // Straps pass two flops before capture
  spfs_sync #(.W(2)) u_strap_sync (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .async_i({ether_strap_pad_i, pci_strap_pad_i}),
    .sync_o(strap_sync)
  );

  // Pad levels pass two flops before use
  spfs_sync #(.W(36)) u_pad_sync (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .async_i({video_port1_data_pad_i, general_io_bank_pad_i}),
    .sync_o({vp_sync, gp_sync})
  );

  // One-shot capture of the synced straps
  spfs_strap_latch u_strap (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .pci_strap_i(strap_sync[0]),
    .ether_strap_i(strap_sync[1]),
    .pci_enable_o(pci_en),
    .ether_strap_enable_o(ether_strap_enable),
    .latched_o(straps_latched)
  );

  ////////////////////////////////////////////////////////////////////////
  // Next state

  spfs_state_t st; // Registered state
  spfs_state_t next_st; // Next state
  logic req; // Bus request present
  logic up_video; // Video owns upper pads
  logic up_audio; // Audio owns upper pads
  logic low_bsp; // Serial port 1 owns lower pads
  logic mac_eff; // Ether enable in effect
  logic [31:0] status; // Status word

  // Ownership of video port 1 pads
  always_comb begin
    up_video = st.cfg[`SPFS_CFG_VP1];
    up_audio = st.cfg[`SPFS_CFG_AUD0] & ~st.cfg[`SPFS_CFG_VP1];
    low_bsp = st.cfg[`SPFS_CFG_BSP1] & ~st.cfg[`SPFS_CFG_VP1];
    mac_eff = ether_strap_enable & ~pci_en;
    // Status word from live ownership
    status = 32'h0;
    status[`SPFS_ST_PCI] = pci_en;
    status[`SPFS_ST_ETHER] = ether_strap_enable;
    status[`SPFS_ST_ETHER_EFF] = mac_eff;
    status[`SPFS_ST_LATCHED] = straps_latched;
    status[`SPFS_ST_UP_VIDEO] = up_video;
    status[`SPFS_ST_UP_AUDIO] = up_audio;
    status[`SPFS_ST_LOW_BSP] = low_bsp;
  end

  // Bus, registers and pad routing
  always_comb begin
    next_st = st;
    req = wb_cyc_i & wb_stb_i;
    // One-cycle ack, dropped the cycle after
    next_st.ack = req & ~st.ack;
    // Read data prepared with the ack
    if (req & ~st.ack) begin
      // Decode the register being read
      if (wb_adr_i == `SPFS_OFF_PERIPHERAL_CONFIG_REG) begin
        next_st.dat = {29'h0, st.cfg};
      end else if (wb_adr_i == `SPFS_OFF_GPEN) begin
        next_st.dat = {16'h0, st.gen};
      end else if (wb_adr_i == `SPFS_OFF_GPDIR) begin
        next_st.dat = {16'h0, st.gdir};
      end else if (wb_adr_i == `SPFS_OFF_GPOUT) begin
        next_st.dat = {16'h0, st.gout};
      end else if (wb_adr_i == `SPFS_OFF_GPIN) begin
        next_st.dat = {16'h0, st.gin};
      end else if (wb_adr_i == `SPFS_OFF_STATUS) begin
        next_st.dat = status;
      end else begin
        // Unmapped reads as zero
        next_st.dat = 32'h0;
      end
    end else begin
      next_st.dat = 32'h0;
    end
    // Writes land on the acked edge
    if (req & st.ack & wb_we_i) begin
      if (wb_adr_i == `SPFS_OFF_PERIPHERAL_CONFIG_REG) begin
        // Config takes the low lane only
        if (wb_sel_i[0]) begin
          next_st.cfg = wb_dat_i[2:0];
        end
      end else if (wb_adr_i == `SPFS_OFF_GPEN) begin
        // Bank registers take both low lanes
        next_st.gen = merge16(st.gen, wb_dat_i, wb_sel_i);
      end else if (wb_adr_i == `SPFS_OFF_GPDIR) begin
        next_st.gdir = merge16(st.gdir, wb_dat_i, wb_sel_i);
      end else if (wb_adr_i == `SPFS_OFF_GPOUT) begin
        next_st.gout = merge16(st.gout, wb_dat_i, wb_sel_i);
      end else begin
        // Read-only and unmapped writes ignored
        next_st.gout = st.gout;
      end
    end
    // GPIO input capture
    next_st.gin = gp_sync;
    // General I/O bank pads
    for (int i = 0; i < 16; i++) begin
      // Software owner first, then defaults
      if (gpio_owns(i, st.gen[i], pci_en)) begin
        next_st.gp_o[i] = st.gout[i];
        next_st.gp_oe[i] = st.gdir[i];
      end else if (i == `SPFS_GP_DIV4) begin
        next_st.gp_o[i] = cpu_div4_clock_out_i;
        next_st.gp_oe[i] = 1'b1;
      end else if (i == `SPFS_GP_DIV6) begin
        next_st.gp_o[i] = cpu_div6_clock_out_i;
        next_st.gp_oe[i] = 1'b1;
      end else if (i == `SPFS_GP_DAC) begin
        next_st.gp_o[i] = vcxo_dac_out_i;
        next_st.gp_oe[i] = 1'b1;
      end else if (i >= `SPFS_GP_PCI_LO && pci_en) begin
        next_st.gp_o[i] = pci_shared_out_i[pci_lane(i)];
        next_st.gp_oe[i] = pci_shared_oe_i[pci_lane(i)];
      end else begin
        // No function: pad floats
        next_st.gp_o[i] = 1'b0;
        next_st.gp_oe[i] = 1'b0;
      end
    end
    // PCI sees its pads only when strapped on
    next_st.pci_in = pci_en ? gp_sync[`SPFS_GP_PCI_HI:`SPFS_GP_PCI_LO] : 7'h0;
    // Dedicated PCI pads tied off while strap is 0
    next_st.pci_ded_oe = pci_en & pci_dedicated_oe_i;
    // Video port 1 pads
    if (up_video) begin
      next_st.vp_o = video_port1_data_out_i;
      next_st.vp_oe = video_port1_data_oe_i;
    end else begin
      next_st.vp_o = 20'h0;
      next_st.vp_oe = 20'h0;
      // Upper pads to audio when enabled
      if (up_audio) begin
        next_st.vp_o[`SPFS_VP_UP_HI:`SPFS_VP_UP_LO] = audio_port0_serial_data_out_i;
        next_st.vp_oe[`SPFS_VP_UP_HI:`SPFS_VP_UP_LO] = audio_port0_serial_data_oe_i;
      end
      // Lower pads to serial port 1
      if (low_bsp) begin
        next_st.vp_o[`SPFS_VP_LOW_HI:`SPFS_VP_LOW_LO] = bsp1_out_i;
        next_st.vp_oe[`SPFS_VP_LOW_HI:`SPFS_VP_LOW_LO] = bsp1_oe_i;
      end
    end
    // Pad levels reach only the owner
    next_st.video_in = up_video ? vp_sync : 20'h0;
    next_st.audio_in = up_audio ? vp_sync[`SPFS_VP_UP_HI:`SPFS_VP_UP_LO] : 8'h0;
    next_st.bsp_in = low_bsp ? vp_sync[`SPFS_VP_LOW_HI:`SPFS_VP_LOW_LO] : 7'h0;
  end

  ////////////////////////////////////////////////////////////////////////
  // State register

  // Reset clears every pad drive; from the first edge after, clock pads on dividers, upper video pads idle, lower on serial port 1
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      st <= '0;
      st.cfg <= `SPFS_CFG_RESET;
    end else begin
      st <= next_st;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Outputs

  logic ether_q; // Registered effective ether enable

  // Ether enable output flop
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      ether_q <= 1'b0;
    end else begin
      ether_q <= mac_eff;
    end
  end

  // Every port below comes from a flop
  assign wb_ack_o = st.ack;
  assign wb_dat_o = st.dat;
  assign ether_strap_enable_o = ether_q;
  assign general_io_bank_pad_o = st.gp_o;
  assign general_io_bank_pad_oe_o = st.gp_oe;
  assign pci_shared_in_o = st.pci_in;
  assign pci_dedicated_oe_o = st.pci_ded_oe;
  assign video_port1_data_pad_o = st.vp_o;
  assign video_port1_data_pad_oe_o = st.vp_oe;
  assign video_port1_data_o = st.video_in;
  assign audio_port0_serial_data_o = st.audio_in;
  assign bsp1_in_o = st.bsp_in;
endmodule : spfs_pin_mux

// ### rtl/spfs_pkg.sv
package spfs_pkg;
  // Strap capture sequence
  typedef enum logic [1:0] {
    SPFS_STRAP_WAIT = 2'b00,
    SPFS_STRAP_HOLD = 2'b01
  } spfs_strap_state_t;

  // Registered state of the pin selector, apart from the ether flop, strap capture and synchronisers
  typedef struct packed {
    logic ack;
    logic [31:0] dat;
    logic [2:0] cfg;
    logic [15:0] gen;
    logic [15:0] gdir;
    logic [15:0] gout;
    logic [15:0] gin;
    logic [15:0] gp_o;
    logic [15:0] gp_oe;
    logic [19:0] vp_o;
    logic [19:0] vp_oe;
    logic [19:0] video_in;
    logic [7:0] audio_in;
    logic [6:0] bsp_in;
    logic [6:0] pci_in;
    logic pci_ded_oe;
  } spfs_state_t;
endpackage : spfs_pkg

// ### rtl/spfs_strap_latch.sv
`include "spfs_map.svh"
module spfs_strap_latch (
  // Clock and reset
  input wire logic clk_i,
  input wire logic reset_i,
  // Synchronised strap levels
  input wire logic pci_strap_i,
  input wire logic ether_strap_i,
  // Latched values
  output logic pci_enable_o,
  output logic ether_strap_enable_o,
  output logic latched_o
);
  import spfs_pkg::*;

  // Capture sequence state
  typedef struct packed {
    spfs_strap_state_t fsm;
    logic [1:0] cnt;
    logic pci;
    logic mac;
  } spfs_latch_t;

  spfs_latch_t st;
  spfs_latch_t next_st;

  // Wait for the synchroniser to fill, then capture once
  always_comb begin
    next_st = st;
    case (st.fsm)
      SPFS_STRAP_WAIT: begin
        if (st.cnt == `SPFS_STRAP_SETTLE) begin
          next_st.pci = pci_strap_i;
          next_st.mac = ether_strap_i;
          next_st.fsm = SPFS_STRAP_HOLD;
        end else begin
          next_st.cnt = st.cnt + 2'h1;
        end
      end
      // Held until the next reset
      SPFS_STRAP_HOLD: begin
        next_st = st;
      end
      default: begin
        next_st.fsm = SPFS_STRAP_WAIT;
      end
    endcase
  end

  // Reset: PCI off, ether off until captured
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      st <= '{fsm: SPFS_STRAP_WAIT, cnt: 2'h0, pci: 1'b0, mac: 1'b0};
    end else begin
      st <= next_st;
    end
  end

  assign pci_enable_o = st.pci;
  assign ether_strap_enable_o = st.mac;
  assign latched_o = (st.fsm == SPFS_STRAP_HOLD);
endmodule : spfs_strap_latch

// ### rtl/spfs_sync.sv
module spfs_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic reset_i,
  // Asynchronous in, synchronous out
  input wire logic [W-1:0] async_i,
  output logic [W-1:0] sync_o
);
  import spfs_pkg::*;

  // Two flop stages
  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] stable;
  } spfs_sync_t;

  spfs_sync_t st;
  spfs_sync_t next_st;

  // First stage feeds only the second stage
  always_comb begin
    next_st.meta = async_i;
    next_st.stable = st.meta;
  end

  // Register both stages
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign sync_o = st.stable;
endmodule : spfs_sync

// ### tb/spfs_pad_partner.sv
////////////////////////////////////////////////////////////
module spfs_pad_partner #(
  parameter int W = 16
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic reset_i,
  // Device side of the pads
  input wire logic [W-1:0] dev_o_i,
  input wire logic [W-1:0] dev_oe_i,
  // Far chip drive
  input wire logic [W-1:0] ext_o_i,
  input wire logic [W-1:0] ext_oe_i,
  // Resolved pad level
  output logic [W-1:0] pad_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // Level of an undriven pad, no pull on these lines
  logic [W-1:0] drift;
  // Undriven pads wander every cycle so a stale value never passes
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      drift <= '0;
    end else begin
      drift <= ~drift;
    end
  end
  // Device first, then far chip, else wandering level
  assign pad_o = (dev_oe_i & dev_o_i) | (~dev_oe_i & ext_oe_i & ext_o_i) | (~dev_oe_i & ~ext_oe_i & drift);
endmodule : spfs_pad_partner

// ### tb/spfs_pin_mux_sva.sv
`include "spfs_map.svh"
module spfs_pin_mux_chk (
  // Clock and reset
  input wire logic clk_i,
  input wire logic reset_i,
  // Bus writes
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [5:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic wb_ack_o,
  // Straps and sources
  input wire logic ether_strap_enable_o,
  input wire logic pci_dedicated_oe_o,
  input wire logic cpu_div4_clock_out_i,
  input wire logic vcxo_dac_out_i,
  input wire logic [6:0] pci_shared_oe_i,
  // Pads and cores
  input wire logic [15:0] general_io_bank_pad_o,
  input wire logic [15:0] general_io_bank_pad_oe_o,
  input wire logic [19:0] video_port1_data_pad_oe_o,
  input wire logic [19:0] video_port1_data_oe_i,
  input wire logic [7:0] audio_port0_serial_data_oe_i,
  input wire logic [6:0] bsp1_oe_i
);
  timeunit 1ns;
  timeprecision 1ps;
  // Shadow of owner registers, rebuilt from bus writes
  typedef struct packed {
    logic [2:0] age;
    logic [2:0] cfg;
    logic [15:0] gen;
    logic [15:0] gdir;
  } spfs_shadow_t;
  spfs_shadow_t s;
  spfs_shadow_t next_s;
  logic wr;
  logic ok;
  // A write lands at the edge that sees ack
  assign wr = wb_stb_i && wb_we_i && wb_ack_o;
  // Straps settled and pads past their first update
  assign ok = s.age == 3'h7;
  ////////////////////////////////////////////////////////////
  // Next shadow value
  always_comb begin
    next_s = s;
    if (!ok) begin
      next_s.age = s.age + 3'h1;
    end
    if (wr && wb_adr_i == `SPFS_OFF_PERIPHERAL_CONFIG_REG && wb_sel_i[0]) begin
      next_s.cfg = wb_dat_i[2:0];
    end
    if (wr && wb_adr_i == `SPFS_OFF_GPEN) begin
      if (wb_sel_i[0]) next_s.gen[7:0] = wb_dat_i[7:0];
      if (wb_sel_i[1]) next_s.gen[15:8] = wb_dat_i[15:8];
    end
    if (wr && wb_adr_i == `SPFS_OFF_GPDIR) begin
      if (wb_sel_i[0]) next_s.gdir[7:0] = wb_dat_i[7:0];
      if (wb_sel_i[1]) next_s.gdir[15:8] = wb_dat_i[15:8];
    end
  end
  // Shadow register, config resets to serial port on
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      s <= {3'h0, `SPFS_CFG_RESET, 32'h0};
    end else begin
      s <= next_s;
    end
  end
  ////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (reset_i);
  property p_div4;
    ok && !$past(s.gen[1]) |-> general_io_bank_pad_oe_o[1] && general_io_bank_pad_o[1] == $past(cpu_div4_clock_out_i);
  endproperty
  a_div4: assert property (p_div4) else $error("clock pad lost its divided clock");
  property p_dir;
    ok && $past(s.gen[0]) |-> general_io_bank_pad_oe_o[0] == $past(s.gdir[0]);
  endproperty
  a_dir: assert property (p_dir) else $error("gpio drive differs from direction");
  property p_dac;
    ok && !$past(s.gen[8]) |-> general_io_bank_pad_oe_o[8] && general_io_bank_pad_o[8] == $past(vcxo_dac_out_i);
  endproperty
  a_dac: assert property (p_dac) else $error("dac pad not carrying dac");
  property p_pci_gp;
    ok && $past(s.gen[15:9]) == 7'h0 |-> (general_io_bank_pad_oe_o[15:9] & ~$past(pci_shared_oe_i)) == 7'h0;
  endproperty
  a_pci_gp: assert property (p_pci_gp) else $error("unowned shared pad driven");
  property p_up_idle;
    ok && $past(s.cfg[1:0]) == 2'h0 |-> video_port1_data_pad_oe_o[19:12] == 8'h0;
  endproperty
  a_up_idle: assert property (p_up_idle) else $error("upper pads driven while idle");
  property p_audio;
    ok && $past(s.cfg[1:0]) == 2'h2 |-> video_port1_data_pad_oe_o[19:12] == $past(audio_port0_serial_data_oe_i);
  endproperty
  a_audio: assert property (p_audio) else $error("upper pads not following audio");
  property p_video;
    ok && $past(s.cfg[0]) |-> video_port1_data_pad_oe_o == $past(video_port1_data_oe_i);
  endproperty
  a_video: assert property (p_video) else $error("pads not following video");
  property p_bsp;
    ok && $past(s.cfg[2]) && !$past(s.cfg[0]) |-> video_port1_data_pad_oe_o[8:2] == $past(bsp1_oe_i);
  endproperty
  a_bsp: assert property (p_bsp) else $error("lower pads not following serial port");
  property p_ether;
    pci_dedicated_oe_o |-> !ether_strap_enable_o;
  endproperty
  a_ether: assert property (p_ether) else $error("ether enabled beside pci");
  // Main scenarios reached
  c_audio: cover property (ok && s.cfg[1:0] == 2'h2);
  c_video: cover property (ok && s.cfg[0]);
  c_gpio: cover property (ok && s.gen[1] && s.gdir[0]);
endmodule : spfs_pin_mux_chk
bind spfs_pin_mux spfs_pin_mux_chk i_spfs_pin_mux_chk (.clk_i, .reset_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
  .wb_dat_i, .wb_ack_o, .ether_strap_enable_o, .pci_dedicated_oe_o, .cpu_div4_clock_out_i, .vcxo_dac_out_i,
  .pci_shared_oe_i, .general_io_bank_pad_o, .general_io_bank_pad_oe_o, .video_port1_data_pad_oe_o,
  .video_port1_data_oe_i, .audio_port0_serial_data_oe_i, .bsp1_oe_i);

// ### tb/tb_top.sv
`include "spfs_map.svh"
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  // Design stimulus and observation
  logic clk_i, reset_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, pci_strap_pad_i, ether_strap_pad_i;
  logic cpu_div4_clock_out_i, cpu_div6_clock_out_i, vcxo_dac_out_i, pci_dedicated_oe_i;
  logic ether_strap_enable_o, pci_dedicated_oe_o;
  logic [5:0] wb_adr_i;
  logic [3:0] wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o, q;
  logic [15:0] general_io_bank_pad_i, general_io_bank_pad_o, general_io_bank_pad_oe_o, gp_ext;
  logic [6:0] pci_shared_out_i, pci_shared_oe_i, pci_shared_in_o, bsp1_out_i, bsp1_oe_i, bsp1_in_o;
  logic [19:0] video_port1_data_pad_i, video_port1_data_pad_o, video_port1_data_pad_oe_o;
  logic [19:0] video_port1_data_out_i, video_port1_data_oe_i, video_port1_data_o;
  logic [7:0] audio_port0_serial_data_out_i, audio_port0_serial_data_oe_i, audio_port0_serial_data_o;
  int num_errors, compares;
  ////////////////////////////////////////////////////////////
  spfs_pin_mux i_spfs_pin_mux (.clk_i, .reset_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
    .wb_dat_o, .wb_ack_o, .pci_strap_pad_i, .ether_strap_pad_i, .ether_strap_enable_o, .cpu_div4_clock_out_i,
    .cpu_div6_clock_out_i, .vcxo_dac_out_i, .general_io_bank_pad_i, .general_io_bank_pad_o,
    .general_io_bank_pad_oe_o, .pci_shared_out_i, .pci_shared_oe_i, .pci_shared_in_o, .pci_dedicated_oe_i,
    .pci_dedicated_oe_o, .video_port1_data_pad_i, .video_port1_data_pad_o, .video_port1_data_pad_oe_o,
    .video_port1_data_out_i, .video_port1_data_oe_i, .video_port1_data_o, .audio_port0_serial_data_out_i,
    .audio_port0_serial_data_oe_i, .audio_port0_serial_data_o, .bsp1_out_i, .bsp1_oe_i, .bsp1_in_o);
  // Far chip on the bank drives pad 2 high
  spfs_pad_partner #(.W(16)) i_spfs_pad_partner_gp (.clk_i, .reset_i, .dev_o_i(general_io_bank_pad_o),
    .dev_oe_i(general_io_bank_pad_oe_o), .ext_o_i(gp_ext), .ext_oe_i(gp_ext), .pad_o(general_io_bank_pad_i));
  // Far chip on the upper video pads
  spfs_pad_partner #(.W(20)) i_spfs_pad_partner_vp (.clk_i, .reset_i, .dev_o_i(video_port1_data_pad_o),
    .dev_oe_i(video_port1_data_pad_oe_o), .ext_o_i(20'h5a000), .ext_oe_i(20'hff000), .pad_o(video_port1_data_pad_i));
  ////////////////////////////////////////////////////////////
  // Clock and a running divided clock
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  always @(posedge clk_i) cpu_div4_clock_out_i <= ~cpu_div4_clock_out_i;
  // Compare one value
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask : chk
  // One classic bus cycle, held until ack
  task automatic wb(input logic we, input logic [5:0] a, input logic [31:0] d);
    int n;
    @(posedge clk_i);
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i, wb_dat_i} <= {2'b11, we, a, 4'hf, d};
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 40);
    q = wb_dat_o;
    {wb_cyc_i, wb_stb_i, wb_we_i} <= 3'b000;
    if (n >= 40) chk("bus ack", 32'h1, 32'h0);
  endtask : wb
  // Read and compare
  task automatic rd(input logic [5:0] a, input logic [31:0] exp, input string name);
    wb(1'b0, a, 32'h0);
    chk(name, exp, q);
  endtask : rd
  // Reset with given strap levels, then let straps latch
  task automatic do_reset(input logic pci, input logic eth);
    @(posedge clk_i);
    {reset_i, pci_strap_pad_i, ether_strap_pad_i} <= {1'b1, pci, eth};
    repeat (10) @(posedge clk_i);
    reset_i <= 1'b0;
    repeat (8) @(posedge clk_i);
  endtask : do_reset
  // Let pad paths settle, sample off the edge
  task automatic settle;
    repeat (4) @(posedge clk_i);
    #1;
  endtask : settle
  ////////////////////////////////////////////////////////////
  // Defaults after reset, PCI off
  task automatic t_defaults;
    do_reset(1'b0, 1'b1);
    rd(`SPFS_OFF_STATUS, 32'h4e, "status");
    rd(`SPFS_OFF_PERIPHERAL_CONFIG_REG, 32'h4, "config");
    settle();
    chk("bank oe", 32'h0106, 32'(general_io_bank_pad_oe_o));
    chk("upper oe", 32'h0, 32'(video_port1_data_pad_oe_o[19:12]));
    chk("lower oe", 32'(bsp1_oe_i), 32'(video_port1_data_pad_oe_o[8:2]));
    chk("bsp in", 32'(bsp1_out_i & bsp1_oe_i), 32'(bsp1_in_o & bsp1_oe_i));
    chk("pci dedicated", 32'h0, 32'(pci_dedicated_oe_o));
    chk("pci in", 32'h0, 32'(pci_shared_in_o));
    chk("ether", 32'h1, 32'(ether_strap_enable_o));
  endtask : t_defaults
  // Software takes bank pads, plus refused accesses
  task automatic t_gpio;
    do_reset(1'b0, 1'b0);
    wb(1'b1, `SPFS_OFF_GPEN, 32'hfe07);
    wb(1'b1, `SPFS_OFF_GPDIR, 32'hfe03);
    wb(1'b1, `SPFS_OFF_GPOUT, 32'haa03);
    settle();
    chk("bank oe", 32'hff03, 32'(general_io_bank_pad_oe_o));
    chk("bank out", 32'hab03, 32'(general_io_bank_pad_o & general_io_bank_pad_oe_o));
    wb(1'b0, `SPFS_OFF_GPIN, 32'h0);
    chk("pad2 in", 32'h1, 32'(q[2]));
    wb(1'b1, `SPFS_OFF_STATUS, 32'hffffffff);
    rd(`SPFS_OFF_STATUS, 32'h48, "status ro");
    rd(6'h3c, 32'h0, "unmapped");
  endtask : t_gpio
  // Audio owns upper pads
  task automatic t_audio;
    logic [7:0] lvl;
    lvl = (audio_port0_serial_data_out_i & audio_port0_serial_data_oe_i) | (8'h5a & ~audio_port0_serial_data_oe_i);
    do_reset(1'b0, 1'b0);
    wb(1'b1, `SPFS_OFF_PERIPHERAL_CONFIG_REG, 32'h6);
    settle();
    chk("upper oe", 32'(audio_port0_serial_data_oe_i), 32'(video_port1_data_pad_oe_o[19:12]));
    chk("audio in", 32'(lvl), 32'(audio_port0_serial_data_o));
    rd(`SPFS_OFF_STATUS, 32'h68, "status");
  endtask : t_audio
  // Video wins over audio and serial port
  task automatic t_video;
    do_reset(1'b0, 1'b0);
    wb(1'b1, `SPFS_OFF_PERIPHERAL_CONFIG_REG, 32'h7);
    settle();
    chk("video oe", 32'(video_port1_data_oe_i), 32'(video_port1_data_pad_oe_o));
    chk("video in", 32'(video_port1_data_out_i & video_port1_data_oe_i),
      32'(video_port1_data_o & video_port1_data_oe_i));
    rd(`SPFS_OFF_STATUS, 32'h18, "status");
  endtask : t_video
  // PCI strapped on, GPIO refused on its pads
  task automatic t_pci;
    do_reset(1'b1, 1'b1);
    rd(`SPFS_OFF_STATUS, 32'h4b, "status");
    wb(1'b1, `SPFS_OFF_GPEN, 32'hff00);
    wb(1'b1, `SPFS_OFF_GPDIR, 32'hff00);
    settle();
    chk("ether", 32'h0, 32'(ether_strap_enable_o));
    chk("pci dedicated", 32'h1, 32'(pci_dedicated_oe_o));
    chk("bank oe hi", 32'({pci_shared_oe_i, 1'b1}), 32'(general_io_bank_pad_oe_o[15:8]));
    chk("pci in", 32'(pci_shared_out_i & pci_shared_oe_i), 32'(pci_shared_in_o & pci_shared_oe_i));
  endtask : t_pci
  ////////////////////////////////////////////////////////////
  // Counts and verdict, then end of run
  task automatic give_verdict;
    $display("compares %0d num_errors %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : give_verdict
  // Hang guard
  initial begin
    repeat (5000) @(posedge clk_i);
    num_errors++;
    give_verdict();
  end
  // Main sequence
  initial begin
    num_errors = 0;
    compares = 0;
    {reset_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i, wb_dat_i} = {4'h8, 6'h0, 4'h0, 32'h0};
    {pci_strap_pad_i, ether_strap_pad_i, cpu_div4_clock_out_i, cpu_div6_clock_out_i} = 4'h1;
    {vcxo_dac_out_i, pci_dedicated_oe_i, pci_shared_out_i, pci_shared_oe_i} = {2'b11, 7'h4c, 7'h35};
    {bsp1_out_i, bsp1_oe_i, audio_port0_serial_data_out_i, audio_port0_serial_data_oe_i} = 30'h1542330f;
    {video_port1_data_out_i, video_port1_data_oe_i} = {20'h3c5a6, 20'hf0f3c};
    gp_ext = 16'h0004;
    t_defaults();
    t_gpio();
    t_audio();
    t_video();
    t_pci();
    give_verdict();
  end
endmodule : tb_top
